/* core/scmt_pkg.sv */
package scmt_pkg;

    // ---------------------------------------------------------------
    // register byte addresses
    // ---------------------------------------------------------------
    localparam logic [5:0] ADDR_TX_STATUS_CTRL = 6'h00;
    localparam logic [5:0] ADDR_RX_STATUS_CTRL = 6'h04;
    localparam logic [5:0] ADDR_RATE_CONTROL   = 6'h08;
    localparam logic [5:0] ADDR_RATE_DIV_LOW   = 6'h0c;
    localparam logic [5:0] ADDR_RATE_DIV_HIGH  = 6'h10;
    localparam logic [5:0] ADDR_TX_HOLDING     = 6'h14;
    localparam logic [5:0] ADDR_PERIPH_FLAG    = 6'h18;
    localparam logic [5:0] ADDR_PERIPH_MASK    = 6'h1c;
    localparam logic [5:0] ADDR_IRQ_CONTROL    = 6'h20;
    localparam logic [5:0] ADDR_EVT_STATUS     = 6'h24;
    localparam logic [5:0] ADDR_EVT_CLEAR      = 6'h28;
    localparam logic [5:0] ADDR_EVT_ENABLE     = 6'h2c;

    // ---------------------------------------------------------------
    // field positions
    // ---------------------------------------------------------------
    localparam int TXSC_MASTER_BIT      = 7;
    localparam int TXSC_NINTH_EN_BIT    = 6;
    localparam int TXSC_TX_EN_BIT       = 5;
    localparam int TXSC_SYNC_BIT        = 4;
    localparam int TXSC_HIGH_SPEED_BIT  = 2;
    localparam int TXSC_SHIFT_EMPTY_BIT = 1;
    localparam int TXSC_NINTH_DATA_BIT  = 0;
    localparam int RXSC_PORT_EN_BIT     = 7;
    localparam int RXSC_RX_EN_BIT       = 4;
    localparam int RXSC_RX_ACTIVE_BIT   = 2;
    localparam int RXSC_CLK_LEVEL_BIT   = 1;
    localparam int RXSC_DATA_LEVEL_BIT  = 0;
    localparam int RATE_IDLE_POL_BIT    = 4;
    localparam int RATE_WIDE_BIT        = 3;
    localparam int FLAG_TX_EMPTY_BIT    = 4;
    localparam int MASK_TX_IRQ_BIT      = 4;
    localparam int IRQC_GLOBAL_BIT      = 7;
    localparam int IRQC_PERIPH_BIT      = 6;
    localparam int EVT_BUF_EMPTY        = 0;
    localparam int EVT_FRAME_DONE       = 1;
    localparam int EVT_W                = 2;

    // ---------------------------------------------------------------
    // reset values and timing
    // ---------------------------------------------------------------
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic       TX_EMPTY_RST   = 1'b1;
    localparam int         CLK_PERIOD_NS  = 5;
    localparam int         ICYC_CLKS      = 4;
    localparam logic [3:0] BITS_BYTE      = 4'h8;
    localparam logic [3:0] BITS_NINE      = 4'h9;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LOAD  = 2'b01,
        ST_SHIFT = 2'b10
    } scmt_state_type;

endpackage

/* core/scmt_rate_if.sv */
`timescale 1ns/1ps
interface scmt_rate_if;
    logic [15:0] divisor;
    logic        wide;
    logic        run;
    logic        icyc_tick;
    logic        rate_tick;

    modport gen  (input divisor, input wide, input run, output icyc_tick, output rate_tick);
    modport user (output divisor, output wide, output run, input icyc_tick, input rate_tick);
endinterface

/* core/scmt_rate_gen.sv */
`timescale 1ns/1ps
module scmt_rate_gen
(
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // rate port
    scmt_rate_if.gen  rate
);

    typedef struct packed {
        logic [1:0]  pre;
        logic [15:0] cnt;
    } scmt_rgen_type;

    scmt_rgen_type q;
    scmt_rgen_type d;
    logic [15:0]   limit;
    logic          icyc;

    // ---------------------------------------------------------------
    // instruction cycle enable and divisor count
    // ---------------------------------------------------------------
    // the narrow mode ignores the high divisor so stale high bits do no harm
    assign limit = rate.wide ? rate.divisor : {8'h00, rate.divisor[7:0]};
    assign icyc  = (q.pre == 2'(scmt_pkg::ICYC_CLKS - 1));

    always_comb
    begin
        d     = q;
        d.pre = icyc ? 2'h0 : q.pre + 2'h1;
        if (!rate.run)
            d.cnt = limit;
        else if (icyc)
            d.cnt = (q.cnt == 16'h0000) ? limit : q.cnt - 16'h0001;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            q <= '0;
        else
            q <= d;
    end

    assign rate.icyc_tick = icyc;
    assign rate.rate_tick = rate.run & icyc & (q.cnt == 16'h0000);

endmodule // scmt_rate_gen

/* core/scmt_sync2.sv */
`timescale 1ns/1ps
module scmt_sync2 #(
    parameter int W = 2
)
(
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // levels
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } scmt_sync_type;

    scmt_sync_type q;
    scmt_sync_type d;

    // only the second stage is ever read outside
    always_comb
    begin
        d.meta = i_d;
        d.stab = q.meta;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            q <= '0;
        else
            q <= d;
    end

    assign o_q = q.stab;

endmodule // scmt_sync2

/* core/scmt_master_tx.sv */
// The placing of the registers and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
// Operation
// - link is half duplex; no reception while transmitting and vice versa.
// - clock source select bit 7 of tx status/control enters master operation.
// - clocked mode select bit 4 of tx status/control selects synchronous operation.
// - port enable bit 7 of rx status/control gives pins to clock and data.
// - in master operation the device drives the shift clock itself.
// - idle polarity bit 4 of rate control sets clock idle level.
// - shifter loads from buffer only after the last bit, immediately if data waits.
// - buffer to shifter transfer takes one instruction cycle, then empty flag sets.
// - transmit interrupt enable gates only the request, never the flag.
// - software cannot clear the empty flag; a buffer write clears it.
// - read-only shifter empty bit 1 of tx status/control, polled only.
// - the shifter is not reachable from the register map.
// - writing the holding buffer while enabled starts shifting that word out.
module scmt_master_tx
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // avalon-mm slave
    input  wire logic [5:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    // shift clock line
    input  wire logic        i_shift_clk_line,
    output logic             o_shift_clk_line,
    output logic             o_shift_clk_line_oe,
    // shift data line
    input  wire logic        i_shift_data_line,
    output logic             o_shift_data_line,
    output logic             o_shift_data_line_oe,
    // interrupt
    output logic             o_irq
);

    typedef struct packed {
        logic                          ph;
        logic [31:0]                   rdata;
        logic [7:0]                    txsc;
        logic [7:0]                    rxsc;
        logic [7:0]                    rctl;
        logic [7:0]                    div_lo;
        logic [7:0]                    div_hi;
        logic [7:0]                    hold;
        logic                          txbe;
        logic                          tx_irq_enable;
        logic [7:0]                    irqc;
        logic [scmt_pkg::EVT_W-1:0]    evt_sts;
        logic [scmt_pkg::EVT_W-1:0]    evt_en;
        scmt_pkg::scmt_state_type      st;
        logic [8:0]                    shreg;
        logic [3:0]                    bits;
        logic                          sclk_act;
        logic                          dout;
    } scmt_tx_type;

    scmt_tx_type                q;
    scmt_tx_type                d;
    logic                       acc_wr;
    logic                       buf_wr;
    logic                       go;
    logic                       port_en;
    logic                       clk_drive;
    logic                       rx_active;
    logic                       shift_empty;
    logic [1:0]                 line_lvl;
    logic [31:0]                rd_val;
    logic [scmt_pkg::EVT_W-1:0] evt_set;
    logic [scmt_pkg::EVT_W-1:0] evt_clr;

    scmt_rate_if rate ();

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    scmt_rate_gen u_rate
    (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .rate  (rate)
    );

    // line levels are only observed, never used to time the shifter
    scmt_sync2 #(.W(2)) u_sync
    (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   ({i_shift_clk_line, i_shift_data_line}),
        .o_q   (line_lvl)
    );

    assign rate.divisor = {q.div_hi, q.div_lo};
    assign rate.wide    = q.rctl[scmt_pkg::RATE_WIDE_BIT];
    assign rate.run     = (q.st == scmt_pkg::ST_SHIFT);

    // ---------------------------------------------------------------
    // mode decode
    // ---------------------------------------------------------------
    assign port_en     = q.rxsc[scmt_pkg::RXSC_PORT_EN_BIT];
    assign clk_drive   = port_en & q.txsc[scmt_pkg::TXSC_SYNC_BIT]
                         & q.txsc[scmt_pkg::TXSC_MASTER_BIT];
    assign go          = clk_drive & q.txsc[scmt_pkg::TXSC_TX_EN_BIT];
    assign shift_empty = (q.st != scmt_pkg::ST_SHIFT);
    assign rx_active   = port_en & q.rxsc[scmt_pkg::RXSC_RX_EN_BIT]
                         & (q.st == scmt_pkg::ST_IDLE);
    assign acc_wr      = i_avs_write & q.ph;
    assign buf_wr      = acc_wr & (i_avs_address == scmt_pkg::ADDR_TX_HOLDING);
    assign evt_clr     = (acc_wr && i_avs_address == scmt_pkg::ADDR_EVT_CLEAR)
                         ? i_avs_writedata[scmt_pkg::EVT_W-1:0] : '0;

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    // the shifter has no address; nothing below exposes it
    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (i_avs_address)
            scmt_pkg::ADDR_TX_STATUS_CTRL:
            begin
                rd_val[7:0]                           = q.txsc;
                rd_val[scmt_pkg::TXSC_SHIFT_EMPTY_BIT] = shift_empty;
            end
            scmt_pkg::ADDR_RX_STATUS_CTRL:
            begin
                rd_val[7:0]                           = q.rxsc;
                rd_val[scmt_pkg::RXSC_RX_ACTIVE_BIT]  = rx_active;
                rd_val[scmt_pkg::RXSC_CLK_LEVEL_BIT]  = line_lvl[1];
                rd_val[scmt_pkg::RXSC_DATA_LEVEL_BIT] = line_lvl[0];
            end
            scmt_pkg::ADDR_RATE_CONTROL:  rd_val[7:0] = q.rctl;
            scmt_pkg::ADDR_RATE_DIV_LOW:  rd_val[7:0] = q.div_lo;
            scmt_pkg::ADDR_RATE_DIV_HIGH: rd_val[7:0] = q.div_hi;
            scmt_pkg::ADDR_TX_HOLDING:    rd_val[7:0] = q.hold;
            scmt_pkg::ADDR_PERIPH_FLAG:   rd_val[scmt_pkg::FLAG_TX_EMPTY_BIT] = q.txbe;
            scmt_pkg::ADDR_PERIPH_MASK:   rd_val[scmt_pkg::MASK_TX_IRQ_BIT] = q.tx_irq_enable;
            scmt_pkg::ADDR_IRQ_CONTROL:   rd_val[7:0] = q.irqc;
            scmt_pkg::ADDR_EVT_STATUS:    rd_val[scmt_pkg::EVT_W-1:0] = q.evt_sts;
            scmt_pkg::ADDR_EVT_ENABLE:    rd_val[scmt_pkg::EVT_W-1:0] = q.evt_en;
            default:                      rd_val = 32'h0000_0000;
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        d       = q;
        evt_set = '0;
        d.ph    = (i_avs_read | i_avs_write) & ~q.ph;
        if (i_avs_read && !q.ph)
            d.rdata = rd_val;

        unique case (q.st)
            scmt_pkg::ST_IDLE:
            begin
                d.sclk_act = 1'b0;
                if (go && !q.txbe && !buf_wr)
                    d.st = scmt_pkg::ST_LOAD;
            end
            scmt_pkg::ST_LOAD:
            begin
                // a buffer write in the same cycle delays the load one
                // instruction cycle, so the flag set never meets its clear
                if (!go)
                    d.st = scmt_pkg::ST_IDLE;
                else if (rate.icyc_tick && !buf_wr)
                begin
                    d.shreg = {q.txsc[scmt_pkg::TXSC_NINTH_DATA_BIT], q.hold};
                    d.bits  = q.txsc[scmt_pkg::TXSC_NINTH_EN_BIT]
                              ? scmt_pkg::BITS_NINE : scmt_pkg::BITS_BYTE;
                    d.dout  = q.hold[0];
                    d.txbe  = 1'b1;
                    evt_set[scmt_pkg::EVT_BUF_EMPTY] = 1'b1;
                    d.st    = scmt_pkg::ST_SHIFT;
                end
            end
            scmt_pkg::ST_SHIFT:
            begin
                if (!go)
                begin
                    d.st       = scmt_pkg::ST_IDLE;
                    d.sclk_act = 1'b0;
                end
                else if (rate.rate_tick && !q.sclk_act)
                    d.sclk_act = 1'b1;
                else if (rate.rate_tick)
                begin
                    d.sclk_act = 1'b0;
                    d.shreg    = {1'b0, q.shreg[8:1]};
                    d.dout     = q.shreg[1];
                    d.bits     = q.bits - 4'h1;
                    if (q.bits == 4'h1)
                    begin
                        evt_set[scmt_pkg::EVT_FRAME_DONE] = 1'b1;
                        d.st = (!q.txbe && !buf_wr) ? scmt_pkg::ST_LOAD : scmt_pkg::ST_IDLE;
                    end
                end
            end
            default:
                d.st = scmt_pkg::ST_IDLE;
        endcase

        if (acc_wr)
        begin
            unique case (i_avs_address)
                scmt_pkg::ADDR_TX_STATUS_CTRL: d.txsc = i_avs_writedata[7:0]
                                                        & ~(8'h01 << scmt_pkg::TXSC_SHIFT_EMPTY_BIT);
                scmt_pkg::ADDR_RX_STATUS_CTRL: d.rxsc = i_avs_writedata[7:0] & 8'hf0;
                scmt_pkg::ADDR_RATE_CONTROL:   d.rctl = i_avs_writedata[7:0];
                scmt_pkg::ADDR_RATE_DIV_LOW:   d.div_lo = i_avs_writedata[7:0];
                scmt_pkg::ADDR_RATE_DIV_HIGH:  d.div_hi = i_avs_writedata[7:0];
                scmt_pkg::ADDR_TX_HOLDING:
                begin
                    d.hold = i_avs_writedata[7:0];
                    d.txbe = 1'b0;
                end
                scmt_pkg::ADDR_PERIPH_MASK:    d.tx_irq_enable = i_avs_writedata[scmt_pkg::MASK_TX_IRQ_BIT];
                scmt_pkg::ADDR_IRQ_CONTROL:    d.irqc = i_avs_writedata[7:0] & 8'hc0;
                scmt_pkg::ADDR_EVT_ENABLE:     d.evt_en = i_avs_writedata[scmt_pkg::EVT_W-1:0];
                // the flag register and unmapped words take writes and ignore them;
                // a load in this cycle must still be able to set the flag
                default:                       ;
            endcase
        end

        // a new event beats a clear in the same cycle
        d.evt_sts = (q.evt_sts & ~evt_clr) | evt_set;
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            q        <= '0;
            q.txsc   <= scmt_pkg::CTRL_RST;
            q.rxsc   <= scmt_pkg::CTRL_RST;
            q.rctl   <= scmt_pkg::CTRL_RST;
            q.txbe   <= scmt_pkg::TX_EMPTY_RST;
            q.st     <= scmt_pkg::ST_IDLE;
        end
        else
            q <= d;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign o_avs_readdata       = q.rdata;
    assign o_avs_waitrequest    = (i_avs_read | i_avs_write) & ~q.ph;
    assign o_shift_clk_line     = q.rctl[scmt_pkg::RATE_IDLE_POL_BIT] ^ q.sclk_act;
    assign o_shift_clk_line_oe  = clk_drive;
    assign o_shift_data_line    = q.dout;
    assign o_shift_data_line_oe = port_en & (q.st != scmt_pkg::ST_IDLE);
    // the flag path needs both global enables; the event path does not
    assign o_irq = (|(q.evt_sts & q.evt_en))
                   | (q.txbe & q.tx_irq_enable & q.irqc[scmt_pkg::IRQC_GLOBAL_BIT]
                      & q.irqc[scmt_pkg::IRQC_PERIPH_BIT]);

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    sequence s_load_step;
        (q.st == scmt_pkg::ST_LOAD) && go && rate.icyc_tick && !buf_wr;
    endsequence

    sequence s_last_fall;
        (q.st == scmt_pkg::ST_SHIFT) && go && rate.rate_tick && q.sclk_act && (q.bits == 4'h1);
    endsequence

    AST_LOAD_SETS_FLAG: assert property (@(posedge i_clk) disable iff (i_rst)
        s_load_step |=> q.txbe && (q.st == scmt_pkg::ST_SHIFT))
        else $error("load did not set empty flag");

    AST_RELOAD_AFTER_LAST: assert property (@(posedge i_clk) disable iff (i_rst)
        s_last_fall ##0 (!q.txbe && !buf_wr) |=> (q.st == scmt_pkg::ST_LOAD) ##[1:4] (q.st == scmt_pkg::ST_SHIFT))
        else $error("waiting word not loaded after last bit");

    AST_BUF_WRITE_CLEARS: assert property (@(posedge i_clk) disable iff (i_rst)
        buf_wr |=> !q.txbe)
        else $error("buffer write did not clear empty flag");

    AST_FLAG_NOT_CLEARABLE: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.txbe && acc_wr && !buf_wr) |=> q.txbe)
        else $error("empty flag cleared without buffer write");

    AST_SHIFT_EMPTY_READ: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_avs_read && !q.ph && i_avs_address == scmt_pkg::ADDR_TX_STATUS_CTRL && q.st == scmt_pkg::ST_SHIFT)
        |=> !o_avs_readdata[scmt_pkg::TXSC_SHIFT_EMPTY_BIT])
        else $error("shifter empty read high while shifting");

    AST_CLK_IDLE_LEVEL: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.st == scmt_pkg::ST_IDLE) |-> (o_shift_clk_line == q.rctl[scmt_pkg::RATE_IDLE_POL_BIT]))
        else $error("clock line not at idle level");

    AST_MASTER_DRIVES_CLK: assert property (@(posedge i_clk) disable iff (i_rst)
        (q.st != scmt_pkg::ST_IDLE) |-> o_shift_clk_line_oe && o_shift_data_line_oe)
        else $error("master not driving lines while transmitting");

    AST_HALF_DUPLEX: assert property (@(posedge i_clk) disable iff (i_rst)
        o_shift_data_line_oe |-> !rx_active)
        else $error("reception active while transmitting");

    AST_LSB_FIRST: assert property (@(posedge i_clk) disable iff (i_rst)
        ((q.st == scmt_pkg::ST_SHIFT) && go && rate.rate_tick && q.sclk_act) |=> (q.dout == $past(q.shreg[1])))
        else $error("data did not advance to next bit");

    AST_NINTH_BIT: assert property (@(posedge i_clk) disable iff (i_rst)
        s_load_step ##0 q.txsc[scmt_pkg::TXSC_NINTH_EN_BIT]
        |=> (q.bits == scmt_pkg::BITS_NINE) && (q.shreg[8] == $past(q.txsc[scmt_pkg::TXSC_NINTH_DATA_BIT])))
        else $error("ninth bit not framed");

    AST_FLAG_IRQ_GATE: assert property (@(posedge i_clk) disable iff (i_rst)
        (!q.tx_irq_enable && q.evt_en == '0) |-> !o_irq)
        else $error("interrupt raised while disabled");

    AST_BUS_ONE_WAIT: assert property (@(posedge i_clk) disable iff (i_rst)
        ((i_avs_read || i_avs_write) && o_avs_waitrequest) |=> !o_avs_waitrequest)
        else $error("bus answer later than one wait state");

endmodule // scmt_master_tx

/* verification/scmt_slave_model.sv */
`timescale 1ns/1ps
module scmt_slave_model
(
    // link pins
    input  wire logic  i_clk_line,
    input  wire logic  i_data_line,
    input  wire logic  i_idle_pol,
    // captured bits
    output logic [8:0] o_word,
    output int         o_count
);
    initial o_word = 9'h000;
    initial o_count = 0;
    // listen only: the data line is never driven back while the master sends
    always @(i_clk_line)
        if (i_clk_line !== i_idle_pol)
        begin
            o_word  <= {i_data_line, o_word[8:1]};
            o_count <= o_count + 1;
        end
endmodule // scmt_slave_model

/* verification/scmt_master_tx_bench.sv */
`timescale 1ns/1ps
module scmt_master_tx_bench;
    // --------------------
    // signals
    // --------------------
    typedef struct packed {logic [7:0] data; logic nine; logic ninth; logic pol; logic [7:0] div;} scmt_row_type;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [5:0]  i_avs_address = 6'h00;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0;
    logic [31:0] o_avs_readdata;
    logic        o_avs_waitrequest, o_shift_clk_line, o_shift_clk_line_oe;
    logic        o_shift_data_line, o_shift_data_line_oe, o_irq;
    logic        pol = 1'b0;
    logic [8:0]  s_word;
    logic [7:0]  q;
    int          s_count, c0, n, n_fail = 0, checks_done = 0;
    // released lines sit at the pull-up level
    wire         clk_line = o_shift_clk_line_oe ? o_shift_clk_line : 1'b1;
    wire         data_line = o_shift_data_line_oe ? o_shift_data_line : 1'b1;
    scmt_row_type rows [3] = '{'{8'ha5, 0, 0, 0, 8'h00}, '{8'h3c, 1, 1, 1, 8'h01}, '{8'h81, 1, 0, 0, 8'h02}};

    scmt_master_tx dut_u (.i_clk, .i_rst, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
        .o_avs_readdata, .o_avs_waitrequest, .i_shift_clk_line(clk_line), .o_shift_clk_line,
        .o_shift_clk_line_oe, .i_shift_data_line(data_line), .o_shift_data_line, .o_shift_data_line_oe, .o_irq);
    scmt_slave_model slave_u (.i_clk_line(clk_line), .i_data_line(data_line), .i_idle_pol(pol),
        .o_word(s_word), .o_count(s_count));

    initial forever #2.5 i_clk = ~i_clk;
    // --------------------
    // tasks
    // --------------------
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
        i_avs_address <= a;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        i_avs_writedata <= {24'h0, d};
        // request stands until waitrequest is sampled low at a rising edge
        @(posedge i_clk);
        for (n = 0; n < 20 && o_avs_waitrequest !== 1'b0; n++) @(posedge i_clk);
        if (n == 20) n_fail++;
        q = o_avs_readdata[7:0];
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        // one idle edge so the next call never re-raises a strobe in this step
        @(posedge i_clk);
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task rd(input logic [5:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(32'(q), 32'(e));
    endtask
    task wait_frame;
        for (n = 0; n < 400 && o_shift_data_line_oe !== 1'b1; n++) @(negedge i_clk);
        for (n = 0; n < 4000 && o_shift_data_line_oe !== 1'b0; n++) @(negedge i_clk);
        if (n == 4000) n_fail++;
        @(posedge i_clk);
    endtask
    task results;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // --------------------
    // tests
    // --------------------
    initial begin
        repeat (20) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        foreach (rows[i])
        begin
            pol = rows[i].pol;
            wr(scmt_pkg::ADDR_RATE_CONTROL, {3'h0, rows[i].pol, 4'h0});
            wr(scmt_pkg::ADDR_RATE_DIV_LOW, rows[i].div);
            wr(scmt_pkg::ADDR_RX_STATUS_CTRL, 8'h80);
            wr(scmt_pkg::ADDR_TX_STATUS_CTRL, {1'b1, rows[i].nine, 5'h18, rows[i].ninth});
            chk(32'(clk_line), 32'(rows[i].pol));
            chk(32'(o_shift_clk_line_oe), 32'h1);
            c0 = s_count;
            wr(scmt_pkg::ADDR_TX_HOLDING, rows[i].data);
            wait_frame();
            chk(32'(s_count - c0), rows[i].nine ? 32'h9 : 32'h8);
            chk(32'(rows[i].nine ? s_word : {1'b0, s_word[8:1]}), {23'h0, rows[i].nine & rows[i].ninth, rows[i].data});
            rd(scmt_pkg::ADDR_TX_STATUS_CTRL, {1'b1, rows[i].nine, 5'h19, rows[i].ninth});
            $display("row %0d done", i);
        end
        // second word written while the first still shifts
        wr(scmt_pkg::ADDR_TX_STATUS_CTRL, 8'hb0);
        c0 = s_count;
        wr(scmt_pkg::ADDR_TX_HOLDING, 8'h5a);
        q = 8'h00;
        for (int k = 0; k < 20 && q !== 8'h10; k++) bus(1'b0, scmt_pkg::ADDR_PERIPH_FLAG, 8'h00);
        chk(32'(q), 32'h10);
        wr(scmt_pkg::ADDR_PERIPH_FLAG, 8'h00);
        rd(scmt_pkg::ADDR_PERIPH_FLAG, 8'h10);
        wr(scmt_pkg::ADDR_TX_HOLDING, 8'hc3);
        rd(scmt_pkg::ADDR_PERIPH_FLAG, 8'h00);
        rd(scmt_pkg::ADDR_TX_STATUS_CTRL, 8'hb0);
        wait_frame();
        chk(32'(s_count - c0), 32'h10);
        chk(32'(s_word[8:1]), 32'hc3);
        $display("back to back done");
        wr(scmt_pkg::ADDR_IRQ_CONTROL, 8'hc0);
        chk(32'(o_irq), 32'h0);
        wr(scmt_pkg::ADDR_PERIPH_MASK, 8'h10);
        chk(32'(o_irq), 32'h1);
        wr(scmt_pkg::ADDR_PERIPH_MASK, 8'h00);
        rd(scmt_pkg::ADDR_EVT_STATUS, 8'h03);
        wr(scmt_pkg::ADDR_EVT_ENABLE, 8'h02);
        chk(32'(o_irq), 32'h1);
        wr(scmt_pkg::ADDR_EVT_CLEAR, 8'h03);
        chk(32'(o_irq), 32'h0);
        wr(6'h30, 8'hff);
        rd(6'h30, 8'h00);
        $display("interrupt and map done");
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        rd(scmt_pkg::ADDR_TX_STATUS_CTRL, 8'h02);
        rd(scmt_pkg::ADDR_PERIPH_FLAG, 8'h10);
        chk(32'(o_shift_clk_line_oe), 32'h0);
        $display("reset done");
        results();
    end
    // hang guard, far beyond the thousand or so cycles the tests need
    initial begin
        #100000;
        n_fail++;
        results();
    end
endmodule // scmt_master_tx_bench
